// [inc/scs_pkg.sv]
// constants and types shared by the status calendar sequencer files
package scs_pkg;

  // ----------------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------------
  localparam int NUM_PORTS = 16;
  localparam int PORT_W    = 4;
  localparam int CAL_MAX   = 32;   // build depth, legal range 32 to 2048
  localparam int SLOT_W    = 5;
  localparam int LEN_W     = 6;
  localparam int MULT_W    = 9;
  localparam int FILL_W    = 16;
  localparam int ADR_W     = 12;
  localparam int GAP_W     = 3;

  // ----------------------------------------------------------------------
  // two-bit status codes on the status link
  // ----------------------------------------------------------------------
  localparam logic [1:0] STAT_STARVING  = 2'h0;
  localparam logic [1:0] STAT_HUNGRY    = 2'h1;
  localparam logic [1:0] STAT_SATISFIED = 2'h2;
  localparam logic [1:0] STAT_FRAMING   = 2'h3;
  localparam logic [1:0] SEL_WORD_CAL0  = 2'h1;
  localparam logic [1:0] SEL_WORD_CAL1  = 2'h2;

  // ----------------------------------------------------------------------
  // register byte offsets and the calendar index mask
  // ----------------------------------------------------------------------
  localparam logic [ADR_W-1:0] REG_CTRL      = 12'h000;
  localparam logic [ADR_W-1:0] REG_STATUS    = 12'h004;
  localparam logic [ADR_W-1:0] REG_LEN0      = 12'h008;
  localparam logic [ADR_W-1:0] REG_MULT0     = 12'h00C;
  localparam logic [ADR_W-1:0] REG_LEN1      = 12'h010;
  localparam logic [ADR_W-1:0] REG_MULT1     = 12'h014;
  localparam logic [ADR_W-1:0] REG_CAL0      = 12'h100;
  localparam logic [ADR_W-1:0] REG_CAL1      = 12'h200;
  localparam logic [ADR_W-1:0] CAL_IDX_MASK  = 12'h07F;

  // ----------------------------------------------------------------------
  // field positions, reset values and clamp limits
  // ----------------------------------------------------------------------
  localparam int CTRL_SWAP_BIT  = 0;
  localparam int CTRL_RUN_BIT   = 1;
  localparam int STS_ACTIVE_BIT = 0;
  localparam int STS_PEND_BIT   = 1;
  localparam int STS_RUN_BIT    = 2;
  localparam logic [LEN_W-1:0]  LEN_RST   = 6'h10;
  localparam logic [MULT_W-1:0] MULT_RST  = 9'h001;
  localparam logic [LEN_W-1:0]  LEN_ONE   = 6'h01;
  localparam logic [LEN_W-1:0]  LEN_PORTS = 6'h10;
  localparam logic [LEN_W-1:0]  LEN_MAX   = 6'h20;
  localparam logic [MULT_W-1:0] MULT_ONE  = 9'h001;
  localparam logic [MULT_W-1:0] MULT_MAX  = 9'h100;
  localparam logic [SLOT_W-1:0] SLOT_ONE  = 5'h01;

  // ----------------------------------------------------------------------
  // values used when the parameters are fixed at build time
  // ----------------------------------------------------------------------
  localparam logic [MULT_W-1:0] FIX_MULT  = 9'h001;
  localparam logic [FILL_W-1:0] FIX_LOWER = 16'h0080;
  localparam logic [FILL_W-1:0] FIX_UPPER = 16'h0100;

  // ----------------------------------------------------------------------
  // timing: status words no faster than a quarter of clk_in
  // ----------------------------------------------------------------------
  localparam int               STAT_MIN_CYCLES = 4;
  localparam logic [GAP_W-1:0] GAP_THR = GAP_W'(STAT_MIN_CYCLES - 1);
  localparam logic [GAP_W-1:0] GAP_TOP = 3'h7;

  // ----------------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    SEQ_IDLE,
    SEQ_FRAME,
    SEQ_SELECT,
    SEQ_SLOT,
    SEQ_DIP
  } scs_seq_t;

endpackage : scs_pkg

// [rtl/scs_fill_class.sv]
// per-port fill level to two-bit status classifier
module scs_fill_class (
  // clock and reset
  input  wire logic                       clk_in,
  input  wire logic                       sys_rst_in,
  // level and thresholds
  input  wire logic [scs_pkg::FILL_W-1:0] fill_in,
  input  wire logic [scs_pkg::FILL_W-1:0] lower_in,
  input  wire logic [scs_pkg::FILL_W-1:0] upper_in,
  // status
  output logic      [1:0]                 stat_out
);
  import scs_pkg::*;

  typedef struct packed {
    logic [1:0] stat;
  } scs_class_t;

  scs_class_t st;
  scs_class_t next_st;

  // starving wins over satisfied if thresholds are crossed by mistake
  always_comb begin
    next_st = st;
    if (fill_in <= lower_in) begin
      next_st.stat = STAT_STARVING;
    end else if (fill_in > upper_in) begin
      next_st.stat = STAT_SATISFIED;
    end else begin
      next_st.stat = STAT_HUNGRY;
    end
  end

  // registered so the sequencer reads a settled value
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      st.stat <= STAT_SATISFIED;
    end else begin
      st <= next_st;
    end
  end

  assign stat_out = st.stat;

endmodule : scs_fill_class

// [rtl/scs_status_calendar_sequencer.sv]
// status channel calendar sequencer with wishbone calendar programming
module scs_status_calendar_sequencer #(
  parameter bit RUNTIME_PROG = 1'b1,
  parameter bit ASYM_EN      = 1'b1,
  parameter bit PROG_LEN_EN  = 1'b0,
  parameter bit HITLESS_EN   = 1'b1
) (
  // clock and reset
  input  wire logic                         clk_in,
  input  wire logic                         sys_rst_in,
  // wishbone slave
  input  wire logic                         wb_cyc_in,
  input  wire logic                         wb_stb_in,
  input  wire logic                         wb_we_in,
  input  wire logic [31:0]                  wb_adr_in,
  input  wire logic [3:0]                   wb_sel_in,
  input  wire logic [31:0]                  wb_dat_in,
  output logic      [31:0]                  wb_dat_out,
  output logic                              wb_ack_out,
  // run-time parameter pins
  input  wire logic [scs_pkg::LEN_W-1:0]    cal_len_in,
  input  wire logic [scs_pkg::MULT_W-1:0]   cal_mult_in,
  input  wire logic [scs_pkg::FILL_W-1:0]   lower_fill_threshold_in,
  input  wire logic [scs_pkg::FILL_W-1:0]   upper_fill_threshold_in,
  // buffer fill levels, same clock domain
  input  wire logic [scs_pkg::NUM_PORTS-1:0][scs_pkg::FILL_W-1:0]
                                            fill_level_in,
  // status link
  input  wire logic                         stat_clk_in,
  output logic      [1:0]                   stat_out,
  output logic                              stat_valid_out,
  output logic                              frame_start_out,
  output logic                              active_cal_out
);
  import scs_pkg::*;

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [1:0][CAL_MAX-1:0][PORT_W-1:0] cal;
    logic [1:0][LEN_W-1:0]               len;
    logic [1:0][MULT_W-1:0]              mult;
    logic                                swap_req;
    logic                                run;
    logic                                active;
    logic                                lclk_s0;
    logic                                lclk_s1;
    logic                                lclk_d;
    logic [GAP_W-1:0]                    gap;
    scs_seq_t                            seq;
    logic [SLOT_W-1:0]                   slot;
    logic [MULT_W-1:0]                   rep;
    logic [LEN_W-1:0]                    f_len;
    logic [MULT_W-1:0]                   f_mult;
    logic [1:0]                          dip;
    logic                                odd;
    logic [1:0]                          stat;
    logic                                stat_valid;
    logic                                frame_start;
    logic                                ack;
    logic [31:0]                         rdata;
  } scs_state_t;

  scs_state_t                     st;
  scs_state_t                     next_st;
  logic [NUM_PORTS-1:0][1:0]      port_stat;
  logic [FILL_W-1:0]              lower_thr;
  logic [FILL_W-1:0]              upper_thr;
  logic                           tick;
  logic                           run_eff;
  logic                           wb_take;
  logic                           hi_zero;
  logic                           in_cal0;
  logic                           in_cal1;
  logic                           new_act;
  logic [ADR_W-1:0]               adr;
  logic [SLOT_W-1:0]              widx;
  logic [31:0]                    rd;
  logic [31:0]                    wr;
  logic [1:0]                     word;
  logic [LEN_W-1:0]               raw_len;
  logic [LEN_W-1:0]               len_lim;
  logic [LEN_W-1:0]               fr_len;
  logic [MULT_W-1:0]              raw_mult;
  logic [MULT_W-1:0]              fr_mult;
  logic [PORT_W-1:0]              slot_port;

  // diagonal parity helper: odd words enter with their bits swapped
  function automatic logic [1:0] scs_rot(input logic [1:0] w,
                                         input logic       odd);
    scs_rot = odd ? {w[0], w[1]} : w;
  endfunction : scs_rot

  // ----------------------------------------------------------------------
  // fill level classification
  // ----------------------------------------------------------------------
  // pins only count in run-time mode; fixed mode uses build values
  assign lower_thr = RUNTIME_PROG ? lower_fill_threshold_in : FIX_LOWER;
  assign upper_thr = RUNTIME_PROG ? upper_fill_threshold_in : FIX_UPPER;

  // one classifier per port
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_class
    scs_fill_class u_class (
      .clk_in     (clk_in),
      .sys_rst_in (sys_rst_in),
      .fill_in    (fill_level_in[p]),
      .lower_in   (lower_thr),
      .upper_in   (upper_thr),
      .stat_out   (port_stat[p])
    );
  end

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_st             = st;
    next_st.stat_valid  = 1'b0;
    next_st.frame_start = 1'b0;
    rd                  = '0;
    wr                  = '0;
    word                = STAT_FRAMING;
    // generation waits for software only when the calendar is software's
    run_eff = (RUNTIME_PROG && ASYM_EN) ? st.run : 1'b1;

    // link clock: two flops, then edge detect on the second only
    next_st.lclk_s0 = stat_clk_in;
    next_st.lclk_s1 = st.lclk_s0;
    next_st.lclk_d  = st.lclk_s1;
    // a fast link clock cannot push words closer than the floor
    tick = st.lclk_s1 & ~st.lclk_d & (st.gap >= GAP_THR);
    if (tick) begin
      next_st.gap = '0;
    end else if (st.gap != GAP_TOP) begin
      next_st.gap = st.gap + 3'h1;
    end

    // bus decode
    wb_take = wb_cyc_in & wb_stb_in & ~st.ack;
    next_st.ack = wb_take;
    adr     = wb_adr_in[ADR_W-1:0];
    hi_zero = (wb_adr_in[31:ADR_W] == '0);
    widx    = wb_adr_in[SLOT_W+1:2];
    in_cal0 = hi_zero & ((adr & ~CAL_IDX_MASK) == REG_CAL0);
    in_cal1 = hi_zero & ((adr & ~CAL_IDX_MASK) == REG_CAL1);

    // read mux; unmapped addresses read as zero
    if (hi_zero) begin
      case (adr)
        REG_CTRL: begin
          rd[CTRL_SWAP_BIT] = st.swap_req;
          rd[CTRL_RUN_BIT]  = st.run;
        end
        REG_STATUS: begin
          rd[STS_ACTIVE_BIT] = st.active;
          rd[STS_PEND_BIT]   = st.swap_req ^ st.active;
          rd[STS_RUN_BIT]    = run_eff;
        end
        REG_LEN0:  rd[LEN_W-1:0]  = st.len[0];
        REG_MULT0: rd[MULT_W-1:0] = st.mult[0];
        REG_LEN1:  rd[LEN_W-1:0]  = st.len[1];
        REG_MULT1: rd[MULT_W-1:0] = st.mult[1];
        default: begin
          if (in_cal0) begin
            rd[PORT_W-1:0] = st.cal[0][widx];
          end else if (in_cal1) begin
            rd[PORT_W-1:0] = st.cal[1][widx];
          end
        end
      endcase
    end

    // byte lanes not selected keep their present value
    for (int b = 0; b < 4; b++) begin
      wr[8*b +: 8] = wb_sel_in[b] ? wb_dat_in[8*b +: 8] : rd[8*b +: 8];
    end

    if (wb_take) begin
      next_st.rdata = wb_we_in ? 32'h0000_0000 : rd;
      if (wb_we_in && hi_zero) begin
        case (adr)
          REG_CTRL: begin
            next_st.swap_req = wr[CTRL_SWAP_BIT];
            next_st.run      = wr[CTRL_RUN_BIT];
          end
          REG_LEN0:  next_st.len[0]  = wr[LEN_W-1:0];
          REG_MULT0: next_st.mult[0] = wr[MULT_W-1:0];
          REG_LEN1:  next_st.len[1]  = wr[LEN_W-1:0];
          REG_MULT1: next_st.mult[1] = wr[MULT_W-1:0];
          default: begin
            if (in_cal0) begin
              next_st.cal[0][widx] = wr[PORT_W-1:0];
            end else if (in_cal1) begin
              next_st.cal[1][widx] = wr[PORT_W-1:0];
            end
          end
        endcase
      end
    end

    // calendar taken into use at the coming frame start
    new_act = (HITLESS_EN && ASYM_EN && RUNTIME_PROG) ?
              st.swap_req : 1'b0;
    if (!RUNTIME_PROG) begin
      raw_len  = LEN_PORTS;
      raw_mult = FIX_MULT;
      len_lim  = LEN_PORTS;
    end else if (ASYM_EN) begin
      raw_len  = st.len[new_act];
      raw_mult = st.mult[new_act];
      len_lim  = LEN_MAX;
    end else begin
      raw_len  = PROG_LEN_EN ? cal_len_in : LEN_PORTS;
      raw_mult = cal_mult_in;
      len_lim  = LEN_PORTS;
    end
    // out-of-range settings are clamped rather than left to misbehave
    if (raw_len == '0) begin
      fr_len = LEN_ONE;
    end else if (raw_len > len_lim) begin
      fr_len = len_lim;
    end else begin
      fr_len = raw_len;
    end
    if (raw_mult == '0) begin
      fr_mult = MULT_ONE;
    end else if (raw_mult > MULT_MAX) begin
      fr_mult = MULT_MAX;
    end else begin
      fr_mult = raw_mult;
    end

    // slot to port; without weighting slot n names port n
    slot_port = (ASYM_EN && RUNTIME_PROG) ?
                st.cal[st.active][st.slot] :
                st.slot[PORT_W-1:0];

    // status word sequencing, one word per tick
    if (tick) begin
      case (st.seq)
        SEQ_IDLE: begin
          word = STAT_FRAMING;
          if (run_eff) begin
            next_st.seq = SEQ_FRAME;
          end
        end
        SEQ_FRAME: begin
          word                = STAT_FRAMING;
          next_st.frame_start = 1'b1;
          next_st.active      = new_act;
          next_st.f_len       = fr_len;
          next_st.f_mult      = fr_mult;
          next_st.slot        = '0;
          next_st.rep         = '0;
          next_st.seq = (HITLESS_EN && ASYM_EN && RUNTIME_PROG) ?
                        SEQ_SELECT : SEQ_SLOT;
        end
        SEQ_SELECT: begin
          word = st.active ? SEL_WORD_CAL1 : SEL_WORD_CAL0;
          next_st.seq = SEQ_SLOT;
        end
        SEQ_SLOT: begin
          word = port_stat[slot_port];
          if ({1'b0, st.slot} == st.f_len - LEN_ONE) begin
            next_st.slot = '0;
            if (st.rep == st.f_mult - MULT_ONE) begin
              next_st.seq = SEQ_DIP;
            end else begin
              next_st.rep = st.rep + MULT_ONE;
            end
          end else begin
            next_st.slot = st.slot + SLOT_ONE;
          end
        end
        SEQ_DIP: begin
          word        = ~st.dip;
          next_st.seq = run_eff ? SEQ_FRAME : SEQ_IDLE;
        end
        default: begin
          word        = STAT_FRAMING;
          next_st.seq = SEQ_IDLE;
        end
      endcase
      next_st.stat       = word;
      next_st.stat_valid = 1'b1;
      // parity restarts at the framing word and covers up to the last slot
      if (st.seq == SEQ_FRAME) begin
        next_st.dip = word;
        next_st.odd = 1'b1;
      end else if (st.seq == SEQ_SELECT || st.seq == SEQ_SLOT) begin
        next_st.dip = st.dip ^ scs_rot(word, st.odd);
        next_st.odd = ~st.odd;
      end
    end
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      st          <= '0;
      st.len      <= {LEN_RST, LEN_RST};
      st.mult     <= {MULT_RST, MULT_RST};
      st.seq      <= SEQ_IDLE;
      st.f_len    <= LEN_RST;
      st.f_mult   <= MULT_RST;
      st.stat     <= STAT_FRAMING;
    end else begin
      st <= next_st;
    end
  end

  assign wb_dat_out      = st.rdata;
  assign wb_ack_out      = st.ack;
  assign stat_out        = st.stat;
  assign stat_valid_out  = st.stat_valid;
  assign frame_start_out = st.frame_start;
  assign active_cal_out  = st.active;

endmodule : scs_status_calendar_sequencer

// [testbench/scs_seq_properties.sv]
// concurrent checks on the sequencer top-level ports
module scs_seq_properties
  import scs_pkg::*;
(
  // clock and reset
  input wire logic       clk_in,
  input wire logic       sys_rst_in,
  // bus handshake
  input wire logic       wb_cyc_in,
  input wire logic       wb_stb_in,
  input wire logic       wb_ack_out,
  // status link
  input wire logic [1:0] stat_out,
  input wire logic       stat_valid_out,
  input wire logic       frame_start_out,
  input wire logic       active_cal_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);
  // select word naming the calendar in use
  logic sel_ok;
  assign sel_ok = stat_valid_out &&
    stat_out == (active_cal_out ? SEL_WORD_CAL1 : SEL_WORD_CAL0);
  // frame word and the quiet gap behind it
  sequence frame_open_s;
    frame_start_out ##1 !stat_valid_out [*3];
  endsequence
  chk_ack_next: assert property (
    wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
    else $error("bus ack missing after request");
  chk_ack_pulse: assert property (
    wb_ack_out |=> !wb_ack_out)
    else $error("bus ack longer than one cycle");
  chk_word_gap: assert property (
    stat_valid_out |=> !stat_valid_out [*3])
    else $error("status words closer than four cycles");
  chk_word_due: assert property (
    stat_valid_out |-> ##[5:12] stat_valid_out)
    else $error("status word cadence lost");
  chk_frame_code: assert property (
    frame_start_out |-> stat_valid_out && stat_out == STAT_FRAMING)
    else $error("frame start without framing code");
  chk_select_first: assert property (
    frame_start_out |=> !stat_valid_out until sel_ok)
    else $error("first word after framing is not the select word");
  chk_select_due: assert property (
    frame_open_s |-> ##[1:12] stat_valid_out)
    else $error("select word late");
  chk_cal_hold: assert property (
    $changed(active_cal_out) |-> frame_start_out || $past(frame_start_out))
    else $error("calendar changed away from frame start");
  // reset must also hold, so this one is not disabled by it
  chk_reset_idle: assert property (disable iff (1'b0)
    sys_rst_in |=> stat_out == STAT_FRAMING && !stat_valid_out &&
                  !wb_ack_out && !active_cal_out)
    else $error("outputs not idle after reset");
endmodule : scs_seq_properties

// [testbench/scs_far_end.sv]
// far-end model: link clock source and status-fed credit scheduler
module scs_far_end #(
  parameter int max_burst_starving = 8,
  parameter int max_burst_hungry   = 4
) (
  // data clock and status link
  input  wire logic       clk_in,
  input  wire logic [1:0] stat_in,
  input  wire logic       valid_in,
  input  wire logic       start_in,
  output logic            stat_clk_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // ------------------------------------------------------------------
  // decode state, calendars loaded by the bench
  // ------------------------------------------------------------------
  logic [1:0] words[$];
  logic [1:0] last[$];
  logic [3:0] cal[2][4];
  int         len[2];
  int         span[2];  // slot words per frame: length times multiplier
  int         credit[16];
  int         frames = 0;
  int         swaps = 0;
  int         cur = 0;
  int         k;
  // link clock runs free, independent of the data clock, toggling every 80 ns
  initial stat_clk_out = 1'b0;
  always #80 stat_clk_out = ~stat_clk_out;
  // capture frames; the select word picks the calendar to decode with
  always @(posedge clk_in) begin
    if (valid_in && start_in) begin
      last = words;
      words = {};
      frames++;
    end
    if (valid_in && frames > 0) begin
      words.push_back(stat_in);
      k = words.size() - 3;
      if (k == -1) begin
        swaps += ((stat_in == 2'h2) != (cur == 1));
        cur = (stat_in == 2'h2);
      end
      // optimistic top-up; a swap never flushes the table
      if (k >= 0 && k < span[cur] && stat_in != 2'h2)
        credit[cal[cur][k % len[cur]]] =
          stat_in == 2'h0 ? max_burst_starving : max_burst_hungry;
    end
  end
endmodule : scs_far_end

// [testbench/testbench.sv]
// self-checking bench for the status calendar sequencer
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import scs_pkg::*;
  typedef struct {
    logic [ADR_W-1:0] adr;
    logic             wr;
    logic [31:0]      wdat;
    logic [31:0]      exp;
  } scs_row_t;
  // ------------------------------------------------------------------
  // signals
  // ------------------------------------------------------------------
  logic clk_in = 1'b0, sys_rst_in = 1'b1;
  logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, wb_ack;
  logic [31:0] wb_adr = '0, wb_dat_w = '0, wb_dat_r, q;
  logic [FILL_W-1:0] lower = 16'h0080, upper = 16'h0100;
  logic [NUM_PORTS-1:0][FILL_W-1:0] fill = '0;
  logic stat_clk, stat_valid, frame_start, active_cal;
  logic [1:0] stat;
  int num_errors = 0, total_checks = 0, cycles = 0;
  // register rows: optional write, then read and expected value
  scs_row_t rows[8] = '{
    '{12'h000, 1'b0, 32'h0000_0000, 32'h0000_0000},
    '{12'h008, 1'b0, 32'h0000_0000, 32'h0000_0010},
    '{12'h014, 1'b0, 32'h0000_0000, 32'h0000_0001},
    '{12'h27C, 1'b0, 32'h0000_0000, 32'h0000_0000},
    '{12'h008, 1'b1, 32'hFFFF_FFFF, 32'h0000_003F},
    '{12'h00C, 1'b1, 32'hFFFF_FFFF, 32'h0000_01FF},
    '{12'h104, 1'b1, 32'h0000_00FF, 32'h0000_000F},
    '{12'h040, 1'b1, 32'h0000_0055, 32'h0000_0000}};
  // length and multiplier pins unused with the bus-programmed calendar
  scs_status_calendar_sequencer dut (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .wb_cyc_in(wb_cyc),
    .wb_stb_in(wb_stb), .wb_we_in(wb_we), .wb_adr_in(wb_adr),
    .wb_sel_in(4'hF), .wb_dat_in(wb_dat_w), .wb_dat_out(wb_dat_r),
    .wb_ack_out(wb_ack), .cal_len_in(6'h10), .cal_mult_in(9'h001),
    .lower_fill_threshold_in(lower), .upper_fill_threshold_in(upper),
    .fill_level_in(fill), .stat_clk_in(stat_clk), .stat_out(stat),
    .stat_valid_out(stat_valid), .frame_start_out(frame_start),
    .active_cal_out(active_cal));
  scs_far_end far (.clk_in(clk_in), .stat_in(stat), .valid_in(stat_valid),
    .start_in(frame_start), .stat_clk_out(stat_clk));
  always #10 clk_in = ~clk_in;
  // hang guard, far above the few hundred cycles the run needs
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  task automatic check(input string n, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", n, e, g);
      num_errors++;
    end
  endtask : check
  // one classic cycle, held until ack is sampled
  task automatic wb_xfer(input logic [ADR_W-1:0] a, input logic we,
                         input logic [31:0] d, output logic [31:0] r);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= 32'(a);
    wb_dat_w <= d;
    @(posedge clk_in);
    while (wb_ack !== 1'b1) @(posedge clk_in);
    r = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk_in);
  endtask : wb_xfer
  task automatic load_cal(input int c, n, m, input int p[4]);
    for (int i = 0; i < 4; i++) begin
      far.cal[c][i] = p[i][3:0];
      wb_xfer((c ? REG_CAL1 : REG_CAL0) + 12'(4 * i), 1'b1, 32'(p[i]), q);
    end
    far.len[c] = n;
    far.span[c] = n * m;
    wb_xfer(c ? REG_LEN1 : REG_LEN0, 1'b1, 32'(n), q);
    wb_xfer(c ? REG_MULT1 : REG_MULT0, 1'b1, 32'(m), q);
  endtask : load_cal
  task automatic wait_frames(input int n);
    int t;
    t = far.frames + n;
    while (far.frames < t) @(posedge clk_in);
  endtask : wait_frames
  // expected frame: framing, select, slots times multiplier, parity
  task automatic frame_check(input int c, input logic [1:0] sel);
    logic [1:0] e[$];
    logic [1:0] d;
    logic [FILL_W-1:0] f;
    e = {STAT_FRAMING, sel};
    for (int i = 0; i < far.span[c]; i++) begin
      f = fill[far.cal[c][i % far.len[c]]];
      e.push_back(f <= lower ? STAT_STARVING :
                  f > upper ? STAT_SATISFIED : STAT_HUNGRY);
    end
    d = 2'h3;
    for (int i = 1; i < e.size(); i++)
      d ^= (i % 2) ? {e[i][0], e[i][1]} : e[i];
    e.push_back(~d);
    check("frame length", 32'(e.size()), 32'(far.last.size()));
    foreach (e[i]) check("frame word", 32'(e[i]), 32'(far.last[i]));
  endtask : frame_check
  task automatic tally_and_finish();
    if (num_errors == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : tally_and_finish
  // main sequence
  initial begin
    repeat (10) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    @(posedge clk_in);
    foreach (rows[i]) begin
      if (rows[i].wr) wb_xfer(rows[i].adr, 1'b1, rows[i].wdat, q);
      wb_xfer(rows[i].adr, 1'b0, 32'h0000_0000, q);
      check("register", rows[i].exp, q);
    end
    // fill levels sitting exactly on both thresholds and just past the upper one
    fill[5] <= 16'h0080;
    fill[2] <= 16'h0100;
    fill[9] <= 16'h0101;
    load_cal(0, 3, 2, '{5, 2, 5, 0});
    load_cal(1, 2, 1, '{9, 2, 0, 0});
    wb_xfer(REG_CTRL, 1'b1, 32'h0000_0002, q);
    wait_frames(2);
    frame_check(0, SEL_WORD_CAL0);
    // no traffic is queued, so nothing can strand across the swap
    wb_xfer(REG_CTRL, 1'b1, 32'h0000_0003, q);
    wait_frames(2);
    frame_check(1, SEL_WORD_CAL1);
    check("swaps", 32'h0000_0001, 32'(far.swaps));
    check("active", 32'h0000_0001, 32'(active_cal));
    wb_xfer(REG_STATUS, 1'b0, 32'h0000_0000, q);
    check("status reg", 32'h0000_0005, q);
    // reset in mid-run returns to idle and defaults
    sys_rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    // outputs seen here were launched by the first reset edge
    check("idle word", 32'(STAT_FRAMING), 32'(stat));
    check("active rst", 32'h0000_0000, 32'(active_cal));
    sys_rst_in <= 1'b0;
    @(posedge clk_in);
    wb_xfer(REG_LEN1, 1'b0, 32'h0000_0000, q);
    check("len rst", 32'h0000_0010, q);
    tally_and_finish();
  end
endmodule : testbench
bind scs_status_calendar_sequencer scs_seq_properties chk (
  .clk_in(clk_in), .sys_rst_in(sys_rst_in), .wb_cyc_in(wb_cyc_in),
  .wb_stb_in(wb_stb_in), .wb_ack_out(wb_ack_out), .stat_out(stat_out),
  .stat_valid_out(stat_valid_out), .frame_start_out(frame_start_out),
  .active_cal_out(active_cal_out));
